// *** hw/swr_map.vh ***
// constants for the sweep and amplitude ramp block
// How it works
// - profile rise loads rising step and rate
// - dwell: rising steps stop and hold at end word
// - profile fall sweeps down to start, holds
// - dwell mode output follows profile pin level
// - no-dwell: profile high starts rising sweep
// - no-dwell: at end, return to start, wait
// - no-dwell ignores falling rate and step
// - continuous clear bits hold accumulators zero
// - auto-clear zeroes on commit or profile change
// - multiplier enable low bypasses amplitude scaling
// - manual mode scales by programmed scale word
// - auto mode: 10-bit counter, rate-paced up/down
// - step code 00/01/10/11 gives 1/2/4/8
// - auto amplitude never exceeds programmed scale word
// - ramp timer counts down, reloads at 1
// - load bit reloads timer on commit, profile
// - ramp pin change or auto entry reloads
// - single-tone: profile pins drive channel ramps
// - sweep plus ramp: aux pins pick channel
// - type 01 amp, 10 freq, 11 phase
// - sweep rate timer: 8-bit, reload at 1
`ifndef SWR_MAP_VH
`define SWR_MAP_VH

// ==========================================================
// channel function register fields
`define SWR_CFR_W 24
`define SWR_CFR_TYPE_HI 23
`define SWR_CFR_TYPE_LO 22
`define SWR_CFR_NODWELL 15
`define SWR_CFR_SWEEP_EN 14
`define SWR_CFR_ACLR_SW 4
`define SWR_CFR_CLR_SW 3
`define SWR_CFR_ACLR_PH 2
`define SWR_CFR_CLR_PH 1
`define SWR_TYPE_NA 2'h0
`define SWR_TYPE_AMP 2'h1
`define SWR_TYPE_FREQ 2'h2
`define SWR_TYPE_PHASE 2'h3
`define SWR_MODLVL_2 2'h0

// ==========================================================
// amplitude control register fields
`define SWR_ACR_OFFSET 8'h06
`define SWR_ACR_W 16
`define SWR_ACR_RESET 16'h0000
`define SWR_ACR_STEP_HI 15
`define SWR_ACR_STEP_LO 14
`define SWR_ACR_MULT_EN 12
`define SWR_ACR_AUTO 11
`define SWR_ACR_LOAD_TMR 10
`define SWR_ACR_ASF_HI 9
`define SWR_ASF_FULL 10'h3ff

`endif

// *** hw/swr_amp_ramp.v ***
// one channel of the output amplitude ramp engine
`timescale 1ns/10ps
`default_nettype none
`include "swr_map.vh"

module swr_amp_ramp
(
  input wire mclk_in,
  input wire rst_n_in,
  input wire [15:0] amp_ctl_in,
  input wire [7:0] ramp_rate_in,
  input wire ramp_up_in,
  input wire ramp_chg_in,
  input wire commit_in,
  input wire prof_chg_in,
  output reg [9:0] scale_out,
  output reg bypass_out
);

// ==========================================================
// step decode
function [9:0] step_of;
  input [1:0] code;
  begin
    step_of = 10'h001 << code;
  end
endfunction

wire mult_en = amp_ctl_in[`SWR_ACR_MULT_EN];
wire auto_on = mult_en & amp_ctl_in[`SWR_ACR_AUTO];
wire load_en = amp_ctl_in[`SWR_ACR_LOAD_TMR];
wire [9:0] lim = amp_ctl_in[`SWR_ACR_ASF_HI:0];
wire [9:0] step = step_of(amp_ctl_in[`SWR_ACR_STEP_HI:`SWR_ACR_STEP_LO]);
reg [7:0] tmr_reg;
reg [7:0] tmr_next;
reg [9:0] cnt_reg;
reg [9:0] cnt_next;
reg auto_d_reg;
reg tick;

// ==========================================================
// ramp rate timer and scale counter
always @*
begin
  tmr_next = tmr_reg;
  cnt_next = cnt_reg;
  tick = 1'b0;
  if (!auto_on)
    tmr_next = 8'h00;
  else if (ramp_chg_in || !auto_d_reg)
    tmr_next = ramp_rate_in;
  else if (load_en && (commit_in || prof_chg_in))
    tmr_next = ramp_rate_in;
  else if (tmr_reg <= 8'h01)
  begin
    tmr_next = ramp_rate_in;
    tick = 1'b1;
  end
  else
    tmr_next = tmr_reg - 8'h01;
  if (tick && ramp_up_in)
  begin
    if (cnt_reg >= lim || lim - cnt_reg <= step)
      cnt_next = lim;
    else
      cnt_next = cnt_reg + step;
  end
  else if (tick)
  begin
    if (cnt_reg <= step)
      cnt_next = 10'h000;
    else
      cnt_next = cnt_reg - step;
  end
end

always @(posedge mclk_in)
begin
  if (!rst_n_in)
  begin
    tmr_reg <= 8'h00;
    cnt_reg <= 10'h000;
    auto_d_reg <= 1'b0;
    scale_out <= `SWR_ASF_FULL;
    bypass_out <= 1'b1;
  end
  else
  begin
    tmr_reg <= tmr_next;
    cnt_reg <= cnt_next;
    auto_d_reg <= auto_on;
    bypass_out <= ~mult_en;
    if (!mult_en)
      scale_out <= `SWR_ASF_FULL;
    else if (!auto_on)
      scale_out <= lim;
    else if (cnt_reg > lim)
      scale_out <= lim;
    else
      scale_out <= cnt_reg;
  end
end

endmodule
`default_nettype wire

// *** hw/swr_sweep_top.v ***
// four-channel linear sweep, accumulator clearing and ramp pin routing
`timescale 1ns/10ps
`default_nettype none
`include "swr_map.vh"

module swr_sweep_top
#(
  parameter TW = 32
)
(
  input wire mclk_in,
  input wire rst_n_in,
  input wire [3:0] profile_pin_in,
  input wire [2:0] aux_control_pins_in,
  input wire commit_in,
  input wire [95:0] channel_function_reg_in,
  input wire [63:0] amplitude_control_reg_in,
  input wire [31:0] amplitude_ramp_rate_in,
  input wire [7:0] mod_level_in,
  input wire [4*TW-1:0] start_tuning_word_in,
  input wire [4*TW-1:0] end_tuning_word_in,
  input wire [4*TW-1:0] rising_step_word_in,
  input wire [4*TW-1:0] falling_step_word_in,
  input wire [31:0] rising_rate_word_in,
  input wire [31:0] falling_rate_word_in,
  output wire [4*TW-1:0] sweep_word_out,
  output wire [4*TW-1:0] phase_acc_out,
  output wire [3:0] sweep_active_out,
  output wire [39:0] amp_scale_out,
  output wire [3:0] amp_bypass_out
);

// ==========================================================
// pin synchronisers
reg [3:0] prof_s1_reg;
reg [3:0] prof_s2_reg;
reg [3:0] prof_d_reg;
reg [2:0] aux_s1_reg;
reg [2:0] aux_s2_reg;
reg cm_s1_reg;
reg cm_s2_reg;
reg cm_d_reg;

always @(posedge mclk_in)
begin
  if (!rst_n_in)
  begin
    prof_s1_reg <= 4'h0;
    prof_s2_reg <= 4'h0;
    prof_d_reg <= 4'h0;
    aux_s1_reg <= 3'h0;
    aux_s2_reg <= 3'h0;
    cm_s1_reg <= 1'b0;
    cm_s2_reg <= 1'b0;
    cm_d_reg <= 1'b0;
  end
  else
  begin
    prof_s1_reg <= profile_pin_in;
    prof_s2_reg <= prof_s1_reg;
    prof_d_reg <= prof_s2_reg;
    aux_s1_reg <= aux_control_pins_in;
    aux_s2_reg <= aux_s1_reg;
    cm_s1_reg <= commit_in;
    cm_s2_reg <= cm_s1_reg;
    cm_d_reg <= cm_s2_reg;
  end
end

// ==========================================================
// shared events
wire commit_p = cm_s2_reg & ~cm_d_reg;
wire [3:0] prof_rise = prof_s2_reg & ~prof_d_reg;
wire [3:0] prof_fall = ~prof_s2_reg & prof_d_reg;
wire prof_chg = |(prof_s2_reg ^ prof_d_reg);
wire [3:0] sw_on_w;
wire [3:0] auto_w;

// ==========================================================
// ramp control pin routing
reg [3:0] ramp_up_reg;
reg [3:0] ramp_up_next;
reg [3:0] ramp_chg_reg;
wire all_single = ~|sw_on_w;
wire sweep_and_ramp = (|sw_on_w) & (|auto_w);
wire [1:0] aux_ch = {aux_s2_reg[0], aux_s2_reg[1]};

always @*
begin
  ramp_up_next = ramp_up_reg;
  if (all_single)
    ramp_up_next = prof_s2_reg;
  else if (sweep_and_ramp)
    ramp_up_next[aux_ch] = ~aux_s2_reg[2];
  else
    ramp_up_next = prof_s2_reg;
end

always @(posedge mclk_in)
begin
  if (!rst_n_in)
  begin
    ramp_up_reg <= 4'h0;
    ramp_chg_reg <= 4'h0;
  end
  else
  begin
    ramp_up_reg <= ramp_up_next;
    ramp_chg_reg <= ramp_up_next ^ ramp_up_reg;
  end
end

// ==========================================================
// per-channel sweep and accumulators
genvar c;
generate
  for (c = 0; c < 4; c = c + 1)
  begin : g_ch
    wire [23:0] channel_function_reg = channel_function_reg_in[c*24 +: 24];
    wire [15:0] amplitude_control = amplitude_control_reg_in[c*16 +: 16];
    wire [TW-1:0] s_word = start_tuning_word_in[c*TW +: TW];
    wire [TW-1:0] e_word = end_tuning_word_in[c*TW +: TW];
    wire [TW-1:0] r_step = rising_step_word_in[c*TW +: TW];
    wire [TW-1:0] f_step = falling_step_word_in[c*TW +: TW];
    wire [7:0] r_rate = rising_rate_word_in[c*8 +: 8];
    wire [7:0] f_rate = falling_rate_word_in[c*8 +: 8];
    wire [1:0] stype = channel_function_reg[`SWR_CFR_TYPE_HI:`SWR_CFR_TYPE_LO];
    wire nodwell = channel_function_reg[`SWR_CFR_NODWELL];
    wire sw_on;
    wire pin = prof_s2_reg[c];
    wire dir;
    wire [TW-1:0] span = e_word - s_word;
    wire sw_clr;
    wire ph_clr;
    reg [7:0] tmr_reg;
    reg [7:0] tmr_next;
    reg [TW-1:0] acc_reg;
    reg [TW-1:0] acc_next;
    reg run_reg;
    reg run_next;
    reg tick;
    reg [TW-1:0] word_reg;
    reg [TW-1:0] ph_reg;
    reg act_reg;

    assign sw_on = channel_function_reg[`SWR_CFR_SWEEP_EN] && (stype != `SWR_TYPE_NA) &&
                   (mod_level_in[c*2 +: 2] == `SWR_MODLVL_2);
    assign dir = nodwell ? run_reg : pin;
    assign sw_clr = channel_function_reg[`SWR_CFR_CLR_SW] ||
                    (channel_function_reg[`SWR_CFR_ACLR_SW] && (commit_p || prof_chg));
    assign ph_clr = channel_function_reg[`SWR_CFR_CLR_PH] ||
                    (channel_function_reg[`SWR_CFR_ACLR_PH] && (commit_p || prof_chg));
    assign sw_on_w[c] = sw_on;
    assign auto_w[c] = amplitude_control[`SWR_ACR_MULT_EN] & amplitude_control[`SWR_ACR_AUTO];

    // sweep rate timer
    always @*
    begin
      tmr_next = tmr_reg;
      tick = 1'b0;
      if (!sw_on)
        tmr_next = 8'h00;
      else if (prof_rise[c])
        tmr_next = r_rate;
      else if (prof_fall[c] && !nodwell)
        tmr_next = f_rate;
      else if (commit_p)
        tmr_next = (dir && !nodwell) || nodwell ? r_rate : f_rate;
      else if (tmr_reg <= 8'h01)
      begin
        tmr_next = (dir || nodwell) ? r_rate : f_rate;
        tick = 1'b1;
      end
      else
        tmr_next = tmr_reg - 8'h01;
    end

    // sweep accumulator, held as offset above the start word
    always @*
    begin
      acc_next = acc_reg;
      run_next = run_reg;
      if (!nodwell)
        run_next = 1'b0;
      else if (prof_rise[c])
        run_next = 1'b1;
      if (!sw_on || sw_clr)
        acc_next = {TW{1'b0}};
      else if (tick && dir)
      begin
        if (acc_reg >= span || span - acc_reg <= r_step)
        begin
          if (nodwell)
          begin
            acc_next = {TW{1'b0}};
            run_next = 1'b0;
          end
          else
            acc_next = span;
        end
        else
          acc_next = acc_reg + r_step;
      end
      else if (tick && !nodwell)
      begin
        if (acc_reg <= f_step)
          acc_next = {TW{1'b0}};
        else
          acc_next = acc_reg - f_step;
      end
    end

    always @(posedge mclk_in)
    begin
      if (!rst_n_in)
      begin
        tmr_reg <= 8'h00;
        acc_reg <= {TW{1'b0}};
        run_reg <= 1'b0;
        word_reg <= {TW{1'b0}};
        ph_reg <= {TW{1'b0}};
        act_reg <= 1'b0;
      end
      else
      begin
        tmr_reg <= tmr_next;
        acc_reg <= acc_next;
        run_reg <= run_next;
        word_reg <= s_word + acc_reg;
        act_reg <= sw_on;
        if (ph_clr)
          ph_reg <= {TW{1'b0}};
        else
          ph_reg <= ph_reg + word_reg;
      end
    end

    assign sweep_word_out[c*TW +: TW] = word_reg;
    assign phase_acc_out[c*TW +: TW] = ph_reg;
    assign sweep_active_out[c] = act_reg;

    swr_amp_ramp u_amp
    (
      .mclk_in(mclk_in),
      .rst_n_in(rst_n_in),
      .amp_ctl_in(amplitude_control),
      .ramp_rate_in(amplitude_ramp_rate_in[c*8 +: 8]),
      .ramp_up_in(ramp_up_reg[c]),
      .ramp_chg_in(ramp_chg_reg[c]),
      .commit_in(commit_p),
      .prof_chg_in(prof_chg),
      .scale_out(amp_scale_out[c*10 +: 10]),
      .bypass_out(amp_bypass_out[c])
    );
  end
endgenerate

endmodule
`default_nettype wire

// *** tb/swr_sweep_props.sv ***
// channel 0 assertions of the sweep and ramp block
`timescale 1ns/10ps
`default_nettype none
module swr_sweep_props #(parameter TW = 32)
(
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic [3:0] profile_pin_in,
  input wire logic [95:0] channel_function_reg_in,
  input wire logic [63:0] amplitude_control_reg_in,
  input wire logic [7:0] mod_level_in,
  input wire logic [4*TW-1:0] start_tuning_word_in,
  input wire logic [4*TW-1:0] end_tuning_word_in,
  input wire logic [4*TW-1:0] sweep_word_out,
  input wire logic [4*TW-1:0] phase_acc_out,
  input wire logic [3:0] sweep_active_out,
  input wire logic [39:0] amp_scale_out,
  input wire logic [3:0] amp_bypass_out
);
  wire [23:0] cf = channel_function_reg_in[23:0];
  wire [15:0] ac = amplitude_control_reg_in[15:0];
  wire [9:0] lim = ac[9:0];
  wire [9:0] sc = amp_scale_out[9:0];
  wire [TW-1:0] sw = sweep_word_out[TW-1:0];
  wire [TW-1:0] pa = phase_acc_out[TW-1:0];
  wire [TW-1:0] st = start_tuning_word_in[TW-1:0];
  wire [TW-1:0] en = end_tuning_word_in[TW-1:0];
  wire act = cf[14] && cf[23:22] != 2'h0 && mod_level_in[1:0] == 2'h0;
  logic [9:0] sc_reg;
  always @(posedge mclk_in) sc_reg <= sc;
  wire [9:0] dlt = sc > sc_reg ? sc - sc_reg : sc_reg - sc;
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  sequence auto_s;
    (ac[12] && ac[11] && $stable(ac)) [*3];
  endsequence
  sequence hold_s;
    (act && !cf[15] && cf[4:3] == 2'h0 && profile_pin_in[0] && sw == en && $stable(cf)) [*4];
  endsequence
  bypass_scale_a: assert property (!ac[12] |=> amp_bypass_out[0] && sc == 10'h3ff)
    else $error("bypass scale wrong");
  manual_scale_a: assert property (ac[12] && !ac[11] |=> sc == $past(lim))
    else $error("manual scale wrong");
  auto_limit_a: assert property (auto_s |-> sc <= lim)
    else $error("auto scale above limit");
  auto_step_a: assert property (auto_s |-> dlt <= (10'h1 << ac[15:14]))
    else $error("auto step too large");
  sweep_gate_a: assert property (1'b1 |=> sweep_active_out[0] == $past(act))
    else $error("sweep enable decode wrong");
  sweep_clear_a: assert property ((cf[3] && act && $stable(st)) [*3] |-> sw == st)
    else $error("sweep not held clear");
  phase_clear_a: assert property (cf[1] [*3] |-> pa == '0)
    else $error("phase not held clear");
  phase_run_a: assert property ((!cf[1] && !cf[2]) [*2] |=> pa == $past(pa) + $past(sw))
    else $error("phase accumulate wrong");
  end_hold_a: assert property (hold_s |=> sw == en)
    else $error("end word not held");
endmodule
`default_nettype wire

// *** tb/swr_ctl_model.sv ***
// controller model driving profile, aux and commit pins
`timescale 1ns/10ps
`default_nettype none
module swr_ctl_model
(
  input wire logic mclk_in,
  output logic [3:0] prof_out,
  output logic [2:0] aux_out,
  output logic commit_out
);
  initial {prof_out, aux_out, commit_out} = 8'h00;
  task pins(input [3:0] p, input [2:0] a);
    @(posedge mclk_in) #1 {prof_out, aux_out} = {p, a};
  endtask
  // one full cycle wide so the synchroniser never misses it
  task commit;
    @(posedge mclk_in) #1 commit_out = 1'b1;
    @(posedge mclk_in) #1 commit_out = 1'b0;
  endtask
endmodule
`default_nettype wire

// *** tb/tb_swr_sweep_top.sv ***
// testbench for the sweep and amplitude ramp block
`timescale 1ns/10ps
`default_nettype none
module tb_swr_sweep_top;
  logic mclk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [95:0] cf = '0;
  logic [7:0] ml = '0;
  logic [63:0] ac = '0;
  logic [31:0] ar = '0, rr = '0, fr = '0;
  logic [127:0] st = '0, en = '0, rs = '0, fs = '0;
  logic [3:0] prof;
  logic [2:0] aux;
  logic cmt;
  wire [127:0] sw, pa;
  wire [3:0] act, byp;
  wire [39:0] sc;
  int num_errors = 0, comparisons = 0, cyc = 0;
  initial forever #2 mclk_in = ~mclk_in;
  swr_ctl_model swr_ctl_model_i (.mclk_in(mclk_in), .prof_out(prof), .aux_out(aux),
    .commit_out(cmt));
  swr_sweep_top swr_sweep_top_i (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
    .profile_pin_in(prof), .aux_control_pins_in(aux), .commit_in(cmt),
    .channel_function_reg_in(cf), .amplitude_control_reg_in(ac),
    .amplitude_ramp_rate_in(ar), .mod_level_in(ml), .start_tuning_word_in(st),
    .end_tuning_word_in(en), .rising_step_word_in(rs), .falling_step_word_in(fs),
    .rising_rate_word_in(rr), .falling_rate_word_in(fr), .sweep_word_out(sw),
    .phase_acc_out(pa), .sweep_active_out(act), .amp_scale_out(sc),
    .amp_bypass_out(byp));
  task cy(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask
  task chk(input [63:0] seen, input [63:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  function [31:0] cur(input bit a, input int c);
    cur = a ? {22'h0, sc[c*10+:10]} : sw[31:0];
  endfunction
  task wv(input bit a, input int c, input [31:0] v);
    int i;
    for (i = 0; i < 3000 && cur(a, c) !== v; i++) cy(1);
    chk(cur(a, c), v);
  endtask
  // cycles until the watched output next changes
  task wch(input bit a, input int c, output int n);
    logic [31:0] v;
    v = cur(a, c);
    for (n = 0; n < 300 && cur(a, c) === v; n++) cy(1);
  endtask
  task end_sim;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  always @(posedge mclk_in)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      num_errors++;
      end_sim;
    end
  end
  task t_amp;
    int k, n;
    ac[31:16] = 16'h1040;
    cy(2);
    chk(cur(1, 1), 32'h40);
    ar[15:8] = 8'h03;
    for (k = 0; k < 4; k++)
    begin
      ac[31:16] = {k[1:0], 4'h6, 10'h100};
      swr_ctl_model_i.pins(4'h0, 3'h0);
      wv(1, 1, 32'h0);
      swr_ctl_model_i.pins(4'h2, 3'h0);
      wch(1, 1, n);
      chk(cur(1, 1), 32'h1 << k);
      wch(1, 1, n);
      chk(n, 3);
      wv(1, 1, 32'h100);
    end
  endtask
  task t_sweep;
    int n;
    st[31:0] = 32'h100;
    en[31:0] = 32'h180;
    rs[31:0] = 32'h20;
    fs[31:0] = 32'h10;
    rr[7:0] = 8'h04;
    fr[7:0] = 8'h02;
    cf[23:0] = 24'h804000;
    cy(4);
    chk(act, 4'h1);
    swr_ctl_model_i.pins(4'h1, 3'h0);
    wch(0, 0, n);
    chk(cur(0, 0), 32'h120);
    wch(0, 0, n);
    chk(n, 4);
    wv(0, 0, 32'h180);
    swr_ctl_model_i.pins(4'h0, 3'h0);
    wch(0, 0, n);
    chk(cur(0, 0), 32'h170);
    wch(0, 0, n);
    chk(n, 2);
    wv(0, 0, 32'h100);
    cf[15] = 1'b1;
    swr_ctl_model_i.pins(4'h1, 3'h0);
    wch(0, 0, n);
    chk(cur(0, 0), 32'h120);
    swr_ctl_model_i.pins(4'h0, 3'h0);
    wch(0, 0, n);
    chk(cur(0, 0), 32'h140);
    wv(0, 0, 32'h100);
    cy(30);
    chk(cur(0, 0), 32'h100);
  endtask
  task t_clear;
    cf[15] = 1'b0;
    swr_ctl_model_i.pins(4'h1, 3'h0);
    wv(0, 0, 32'h180);
    cf[3] = 1'b1;
    cy(3);
    chk(cur(0, 0), 32'h100);
    cf[3] = 1'b0;
    wv(0, 0, 32'h180);
    cf[4] = 1'b1;
    swr_ctl_model_i.commit;
    wv(0, 0, 32'h100);
    cf[4] = 1'b0;
    cf[1] = 1'b1;
    cy(3);
    chk(pa[31:0], 32'h0);
    cf[1] = 1'b0;
    ml[1:0] = 2'h1;
    cy(2);
    chk(act[0], 1'b0);
    ml[1:0] = 2'h0;
    cf[23:22] = 2'h0;
    cy(2);
    chk(act[0], 1'b0);
    cf[23:22] = 2'h2;
    cy(2);
    chk(act[0], 1'b1);
  endtask
  task t_aux;
    ac[31:16] = 16'hd900;
    swr_ctl_model_i.pins(4'h2, 3'h6);
    wv(1, 1, 32'h0);
    swr_ctl_model_i.pins(4'h0, 3'h2);
    wv(1, 1, 32'h100);
  endtask
  initial
  begin
    repeat (12) @(posedge mclk_in);
    #1 rst_n_in = 1'b1;
    chk(byp, 4'hf);
    chk(sc, 40'hffffffffff);
    cy(2);
    t_amp;
    t_sweep;
    t_clear;
    t_aux;
    end_sim;
  end
endmodule
bind swr_sweep_top swr_sweep_props #(.TW(TW)) swr_sweep_props_i (
  .mclk_in(mclk_in),
  .rst_n_in(rst_n_in),
  .profile_pin_in(profile_pin_in),
  .channel_function_reg_in(channel_function_reg_in),
  .amplitude_control_reg_in(amplitude_control_reg_in),
  .mod_level_in(mod_level_in),
  .start_tuning_word_in(start_tuning_word_in),
  .end_tuning_word_in(end_tuning_word_in),
  .sweep_word_out(sweep_word_out),
  .phase_acc_out(phase_acc_out),
  .sweep_active_out(sweep_active_out),
  .amp_scale_out(amp_scale_out),
  .amp_bypass_out(amp_bypass_out)
);
`default_nettype wire
